// File: design/report_pkg.sv
// Package with constants for the hardcopy report scheduler
package report_pkg;
	// Register offsets (word addresses on the plain register port)
	localparam logic [3:0] ADDR_CONFIG = 4'h0;
	localparam logic [3:0] ADDR_INTERVAL = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_ELAPSED = 4'h3;
	localparam logic [3:0] ADDR_SEQUENCE = 4'h4;
	localparam logic [3:0] ADDR_COMMAND = 4'h5;
	// Config and command field positions
	localparam int CFG_IFACE_LSB = 0;
	localparam int CFG_MEAS_DISP = 2;
	localparam int CFG_STAT_DISP = 3;
	localparam int CFG_STAT_EN = 4;
	localparam int CFG_INT_EXTERNAL_TRIGGER_INPUT = 5;
	localparam int CMD_KEY_PRINT = 0;
	localparam int CMD_KEY_EXTERNAL_TRIGGER_INPUT = 1;
	// Interface choices
	localparam logic [1:0] IFACE_SERIAL = 2'h0;
	localparam logic [1:0] IFACE_PARALLEL = 2'h1;
	localparam logic [1:0] IFACE_PRINTER = 2'h2;
	// Reset values and limits
	localparam logic [7:0] CONFIG_RESET = 8'h04;
	localparam logic [11:0] INTERVAL_RESET = 12'h000;
	localparam logic [11:0] INTERVAL_MAX = 12'he10;
	localparam logic [14:0] SEQ_FIRST = 15'h0001;
	localparam logic [14:0] SEQ_LAST = 15'h7530;
	localparam logic [6:0] HOURS_WRAP = 7'h64;
	localparam logic [5:0] SIXTY = 6'h3c;
	// Timing
	localparam int CLK_HZ = 10_000_000;
	localparam int TICK_SECONDS = 1;
	localparam int TICK_CYCLES = CLK_HZ * TICK_SECONDS;
	// Report kinds
	typedef enum logic [2:0] {
		KIND_VALUE = 3'h0,
		KIND_INTERVAL = 3'h1,
		KIND_STATS = 3'h2,
		KIND_COUNT_ONLY = 3'h3,
		KIND_STATS_ONE = 3'h4
	} report_kind_t;
endpackage : report_pkg

// File: design/pin_sync.sv
// Two-stage synchroniser with falling edge detect for an active-low pin
`timescale 1ns/1ps
module pin_sync (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Pin and pulse
	input wire logic pin_n,
	output logic fall_pulse
);
	logic meta_q;
	logic sync_q;
	logic last_q;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			last_q <= 1'b1;
			fall_pulse <= 1'b0;
		end else begin
			meta_q <= pin_n;
			sync_q <= meta_q;
			last_q <= sync_q;
			fall_pulse <= last_q & ~sync_q;
		end
	end
endmodule : pin_sync

// File: design/report_scheduler.sv
// Hardcopy report scheduler: decides when reports go to the printer
`timescale 1ns/1ps
module report_scheduler
	import report_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// External control pins, active low
	input wire logic print_req_n,
	input wire logic external_trigger_input_n,
	// Statistics state from the statistics unit
	input wire logic [14:0] valid_count,
	// Report request to the text formatter
	output logic report_strobe,
	output logic [2:0] report_kind,
	output logic [14:0] report_seq,
	output logic [6:0] stamp_hours,
	output logic [5:0] stamp_minutes,
	output logic [5:0] stamp_seconds,
	output logic stat_add_strobe,
	output logic interval_active
);
	logic [7:0] config_q;
	logic [11:0] interval_q;
	logic [31:0] tick_cnt_q;
	logic tick_q;
	logic [11:0] countdown_q;
	logic [6:0] hours_q;
	logic [5:0] minutes_q;
	logic [5:0] seconds_q;
	logic [6:0] hours_d;
	logic [5:0] minutes_d;
	logic [5:0] seconds_d;
	logic [14:0] seq_q;
	logic pin_print;
	logic pin_external_trigger_input;
	logic key_print;
	logic key_external_trigger_input;
	logic print_req;
	logic external_trigger_input_req;
	logic printer_sel;
	logic meas_disp;
	logic stat_disp;
	logic expire;
	logic fire;
	report_kind_t kind_d;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_RUN = 1'b1
	} run_state_t;
	run_state_t state_q;

	pin_sync u_print_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.pin_n(print_req_n),
		.fall_pulse(pin_print)
	);

	pin_sync u_external_trigger_input_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.pin_n(external_trigger_input_n),
		.fall_pulse(pin_external_trigger_input)
	);

	assign key_print = reg_wr && reg_addr == ADDR_COMMAND &&
		reg_wdata[CMD_KEY_PRINT];
	assign key_external_trigger_input = reg_wr && reg_addr == ADDR_COMMAND &&
		reg_wdata[CMD_KEY_EXTERNAL_TRIGGER_INPUT];
	// allows the print pin to be fed by measurement done; any fall counts
	assign print_req = key_print | pin_print;
	assign external_trigger_input_req = key_external_trigger_input | pin_external_trigger_input;
	assign printer_sel =
		config_q[CFG_IFACE_LSB +: 2] == IFACE_PRINTER;
	assign meas_disp = config_q[CFG_MEAS_DISP];
	assign stat_disp = config_q[CFG_STAT_DISP];
	assign expire = state_q == ST_RUN && tick_q &&
		countdown_q == 12'h001;

	// Configuration registers
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			config_q <= CONFIG_RESET;
			interval_q <= INTERVAL_RESET;
		end else if (reg_wr) begin
			if (reg_addr == ADDR_CONFIG)
				config_q <= reg_wdata[7:0];
			// Out-of-range values are refused so the countdown stays bounded
			if (reg_addr == ADDR_INTERVAL &&
				reg_wdata[11:0] <= INTERVAL_MAX &&
				reg_wdata[15:12] == 4'h0)
				interval_q <= reg_wdata[11:0];
		end
	end

	// Run state of interval reporting
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (print_req && meas_disp && printer_sel &&
						interval_q != 12'h000)
						state_q <= ST_RUN;
				end
				ST_RUN: begin
					if (!meas_disp || !printer_sel)
						state_q <= ST_IDLE;
					else if (interval_q == 12'h000)
						state_q <= ST_IDLE;
					else if (print_req)
						state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// One-second tick, restarted when interval reporting starts
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tick_cnt_q <= 32'h0;
			tick_q <= 1'b0;
		end else if (state_q == ST_IDLE) begin
			tick_cnt_q <= 32'h0;
			tick_q <= 1'b0;
		end else if (tick_cnt_q == 32'(TICK_LEN - 1)) begin
			tick_cnt_q <= 32'h0;
			tick_q <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h1;
			tick_q <= 1'b0;
		end
	end

	// Interval countdown
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			countdown_q <= 12'h000;
		end else if (state_q == ST_IDLE) begin
			countdown_q <= interval_q;
		end else if (tick_q) begin
			if (countdown_q == 12'h001)
				countdown_q <= interval_q;
			else
				countdown_q <= countdown_q - 12'h001;
		end
	end

	// Elapsed time after this edge, hh:mm:ss
	always_comb begin
		seconds_d = seconds_q;
		minutes_d = minutes_q;
		hours_d = hours_q;
		if (tick_q) begin
			if (seconds_q == SIXTY - 6'h01) begin
				seconds_d = 6'h00;
				if (minutes_q == SIXTY - 6'h01) begin
					minutes_d = 6'h00;
					if (hours_q == HOURS_WRAP - 7'h01)
						hours_d = 7'h00;
					else
						hours_d = hours_q + 7'h01;
				end else begin
					minutes_d = minutes_q + 6'h01;
				end
			end else begin
				seconds_d = seconds_q + 6'h01;
			end
		end
	end

	// Elapsed time registers, cleared while idle so a new run starts at zero
	always_ff @(posedge mclk) begin
		if (!rst_n || state_q == ST_IDLE) begin
			hours_q <= 7'h00;
			minutes_q <= 6'h00;
			seconds_q <= 6'h00;
		end else begin
			hours_q <= hours_d;
			minutes_q <= minutes_d;
			seconds_q <= seconds_d;
		end
	end

	// Decide whether a report goes out this cycle and of what kind
	always_comb begin
		fire = 1'b0;
		kind_d = KIND_VALUE;
		if (printer_sel) begin
			if (expire) begin
				fire = 1'b1;
				kind_d = KIND_INTERVAL;
			end else if (print_req && stat_disp) begin
				fire = 1'b1;
				if (valid_count == 15'h0000)
					kind_d = KIND_COUNT_ONLY;
				else if (valid_count == 15'h0001)
					kind_d = KIND_STATS_ONE;
				else
					kind_d = KIND_STATS;
			end else if (print_req && meas_disp &&
				interval_q == 12'h000) begin
				fire = 1'b1;
				kind_d = KIND_VALUE;
			end else if (external_trigger_input_req && meas_disp &&
				config_q[CFG_STAT_EN] && config_q[CFG_INT_EXTERNAL_TRIGGER_INPUT]) begin
				fire = 1'b1;
				kind_d = KIND_VALUE;
			end
		end
	end

	// Sequence count of value and interval reports
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			seq_q <= SEQ_FIRST;
		end else if (fire && kind_d != KIND_STATS &&
			kind_d != KIND_STATS_ONE && kind_d != KIND_COUNT_ONLY) begin
			if (seq_q == SEQ_LAST)
				seq_q <= SEQ_FIRST;
			else
				seq_q <= seq_q + 15'h0001;
		end
	end

	// Report outputs; the printer needs no handshake so a strobe suffices
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			report_strobe <= 1'b0;
			report_kind <= 3'h0;
			report_seq <= SEQ_FIRST;
			stamp_hours <= 7'h00;
			stamp_minutes <= 6'h00;
			stamp_seconds <= 6'h00;
			stat_add_strobe <= 1'b0;
			interval_active <= 1'b0;
		end else begin
			report_strobe <= fire;
			if (fire) begin
				report_kind <= kind_d;
				report_seq <= seq_q;
				// An expiry falls on a tick, so the stamp counts that second
				stamp_hours <= hours_d;
				stamp_minutes <= minutes_d;
				stamp_seconds <= seconds_d;
			end
			stat_add_strobe <= external_trigger_input_req && config_q[CFG_STAT_EN] &&
				config_q[CFG_INT_EXTERNAL_TRIGGER_INPUT];
			interval_active <= state_q == ST_RUN;
		end
	end

	// Register read port
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				ADDR_CONFIG: reg_rdata <= {8'h00, config_q};
				ADDR_INTERVAL: reg_rdata <= {4'h0, interval_q};
				ADDR_STATUS: reg_rdata <= {15'h0000, state_q == ST_RUN};
				ADDR_ELAPSED: reg_rdata <= {3'h0, hours_q[6:0],
					seconds_q};
				ADDR_SEQUENCE: reg_rdata <= {1'b0, seq_q};
				default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end
endmodule : report_scheduler

// File: testbench/report_scheduler_monitor.sv
// Checker for the report scheduler ports
`timescale 1ns/1ps
module report_scheduler_monitor
	import report_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Watched ports
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic [14:0] valid_count,
	input wire logic report_strobe,
	input wire logic [2:0] report_kind,
	input wire logic [14:0] report_seq,
	input wire logic [6:0] stamp_hours,
	input wire logic [5:0] stamp_minutes,
	input wire logic [5:0] stamp_seconds,
	input wire logic stat_add_strobe,
	input wire logic interval_active
);
	// Shadows follow the bus, so refused interval writes are skipped too
	logic [7:0] cfg_q;
	logic [11:0] ivl_q;
	wire cw = reg_wr && reg_addr == ADDR_COMMAND;
	wire kp = cw && reg_wdata[CMD_KEY_PRINT];
	wire kt = cw && reg_wdata[CMD_KEY_EXTERNAL_TRIGGER_INPUT];
	wire prn = cfg_q[1:0] == IFACE_PRINTER;
	wire vd = prn && cfg_q[CFG_MEAS_DISP] && !cfg_q[CFG_STAT_DISP];
	always_ff @(posedge mclk) begin
		if (!rst_n) cfg_q <= CONFIG_RESET;
		else if (reg_wr && reg_addr == ADDR_CONFIG) cfg_q <= reg_wdata[7:0];
	end
	always_ff @(posedge mclk) begin
		if (!rst_n) ivl_q <= INTERVAL_RESET;
		else if (reg_wr && reg_addr == ADDR_INTERVAL && reg_wdata <= 16'h0e10)
			ivl_q <= reg_wdata[11:0];
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	property p_route;
		report_strobe |-> $past(prn);
	endproperty
	a_route: assert property (p_route) else $error("report off printer");
	property p_single;
		kp && vd && ivl_q == 0 && !interval_active |=>
			report_strobe && report_kind == KIND_VALUE;
	endproperty
	a_single: assert property (p_single) else $error("no value report");
	property p_start;
		kp && vd && ivl_q != 0 && !interval_active |=> ##1 interval_active;
	endproperty
	a_start: assert property (p_start) else $error("interval not started");
	property p_stop;
		kp && interval_active |=> ##1 !interval_active;
	endproperty
	a_stop: assert property (p_stop) else $error("interval not stopped");
	property p_halt;
		interval_active && !cfg_q[CFG_MEAS_DISP] |-> ##[1:2] !interval_active;
	endproperty
	a_halt: assert property (p_halt) else $error("interval not halted");
	property p_add;
		kt && cfg_q[CFG_STAT_EN] && cfg_q[CFG_INT_EXTERNAL_TRIGGER_INPUT] |=> stat_add_strobe;
	endproperty
	a_add: assert property (p_add) else $error("no statistics add");
	property p_kind;
		kp && prn && cfg_q[CFG_STAT_DISP] && !cfg_q[CFG_MEAS_DISP] |=>
			report_strobe && report_kind == ($past(valid_count) == 0 ?
			KIND_COUNT_ONLY : $past(valid_count) == 1 ? KIND_STATS_ONE : KIND_STATS);
	endproperty
	a_kind: assert property (p_kind) else $error("wrong stats kind");
	property p_stamp;
		report_strobe |-> stamp_hours < HOURS_WRAP &&
			stamp_minutes < SIXTY && stamp_seconds < SIXTY;
	endproperty
	a_stamp: assert property (p_stamp) else $error("bad stamp");
	property p_seq;
		report_strobe |-> report_seq >= SEQ_FIRST && report_seq <= SEQ_LAST;
	endproperty
	a_seq: assert property (p_seq) else $error("sequence out of range");
endmodule : report_scheduler_monitor

bind report_scheduler report_scheduler_monitor u_mon (
	.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .valid_count(valid_count), .report_strobe(report_strobe),
	.report_kind(report_kind), .report_seq(report_seq),
	.stamp_hours(stamp_hours), .stamp_minutes(stamp_minutes),
	.stamp_seconds(stamp_seconds), .stat_add_strobe(stat_add_strobe),
	.interval_active(interval_active));

// File: testbench/printer_model.sv
// Printer model: logs every report as it arrives
`timescale 1ns/1ps
module printer_model (
	// Clock
	input wire logic mclk,
	// Report in
	input wire logic report_strobe,
	input wire logic [2:0] report_kind,
	input wire logic [14:0] report_seq,
	input wire logic [5:0] stamp_seconds,
	// Log out
	output int n_rep,
	output logic [2:0] kind,
	output logic [14:0] seq,
	output logic [5:0] sec,
	output int gap
);
	int now = 0;
	int last = 0;
	initial n_rep = 0;
	// No handshake exists, so the sender is never held back
	always @(posedge mclk) begin
		now++;
		if (report_strobe) begin
			n_rep++;
			kind = report_kind;
			seq = report_seq;
			sec = stamp_seconds;
			gap = now - last;
			last = now;
		end
	end
endmodule : printer_model

// File: testbench/report_scheduler_tb.sv
// Self-checking bench for the report scheduler
`timescale 1ns/1ps
module report_scheduler_tb
	import report_pkg::*;
;
	logic mclk = 0;
	logic rst_n = 0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic print_req_n = 1;
	logic external_trigger_input_n = 1;
	logic [14:0] valid_count = 15'h0000;
	logic [15:0] reg_rdata, v;
	logic report_strobe, stat_add_strobe, interval_active;
	logic [2:0] report_kind, kind;
	logic [14:0] report_seq, seq;
	logic [6:0] stamp_hours;
	logic [5:0] stamp_minutes, stamp_seconds, sec;
	int n_rep, gap, k, n_add = 0, fails = 0, tests_run = 0, cycles = 0;
	always #50 mclk = ~mclk;
	report_scheduler #(.TICK_LEN(10)) u_dut (.mclk(mclk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .print_req_n(print_req_n),
		.external_trigger_input_n(external_trigger_input_n),
		.valid_count(valid_count), .report_strobe(report_strobe),
		.report_kind(report_kind), .report_seq(report_seq),
		.stamp_hours(stamp_hours), .stamp_minutes(stamp_minutes),
		.stamp_seconds(stamp_seconds), .stat_add_strobe(stat_add_strobe),
		.interval_active(interval_active));
	printer_model u_prn (.mclk(mclk), .report_strobe(report_strobe),
		.report_kind(report_kind), .report_seq(report_seq),
		.stamp_seconds(stamp_seconds), .n_rep(n_rep), .kind(kind), .seq(seq),
		.sec(sec), .gap(gap));
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string n, input logic [15:0] e, g);
		tests_run++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			fails++;
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic key(input logic [15:0] d);
		wr(ADDR_COMMAND, d);
	endtask : key
	task automatic settle;
		repeat (8) @(posedge mclk);
	endtask : settle
	// Longest path is the sequence wrap, about 60000 cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 90000) begin
			fails++;
			report_and_stop();
		end
	end
	always @(posedge mclk) if (stat_add_strobe) n_add++;
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		rd(ADDR_CONFIG, v);
		chk("config", 16'(CONFIG_RESET), v);
		rd(ADDR_SEQUENCE, v);
		chk("sequence", 16'(SEQ_FIRST), v);
		rd(4'hf, v);
		chk("unmapped", 16'h0000, v);
		for (int i = 0; i < 2; i++) begin
			wr(ADDR_CONFIG, 16'h0004 | 16'(i));
			key(16'h0001);
		end
		settle;
		chk("off printer", 16'h0000, 16'(n_rep));
		wr(ADDR_INTERVAL, 16'h0e11);
		rd(ADDR_INTERVAL, v);
		chk("refused", 16'h0000, v);
		wr(ADDR_INTERVAL, 16'(INTERVAL_MAX));
		rd(ADDR_INTERVAL, v);
		chk("max", 16'h0e10, v);
		wr(ADDR_INTERVAL, 16'h0000);
		wr(ADDR_CONFIG, 16'h0006);
		key(16'h0001);
		settle;
		chk("one report", 16'h0001, 16'(n_rep));
		chk("value kind", 16'(KIND_VALUE), 16'(kind));
		print_req_n <= 1'b0;
		settle;
		print_req_n <= 1'b1;
		settle;
		chk("pin report", 16'h0002, 16'(n_rep));
		wr(ADDR_CONFIG, 16'h0036);
		key(16'h0002);
		external_trigger_input_n <= 1'b0;
		settle;
		external_trigger_input_n <= 1'b1;
		settle;
		chk("adds", 16'h0002, 16'(n_add));
		chk("external_trigger_input reports", 16'h0004, 16'(n_rep));
		wr(ADDR_CONFIG, 16'h000a);
		for (int i = 0; i < 3; i++) begin
			valid_count <= 15'(i);
			key(16'h0001);
			settle;
			chk("stats kind", 16'(i == 0 ? KIND_COUNT_ONLY : i == 1 ?
				KIND_STATS_ONE : KIND_STATS), 16'(kind));
		end
		wr(ADDR_CONFIG, 16'h0006);
		rd(ADDR_SEQUENCE, v);
		for (int i = int'(v); i <= 30000; i++) key(16'h0001);
		settle;
		chk("last seq", 16'(SEQ_LAST), 16'(seq));
		key(16'h0001);
		settle;
		chk("wrapped seq", 16'(SEQ_FIRST), 16'(seq));
		wr(ADDR_INTERVAL, 16'h0002);
		key(16'h0001);
		rd(ADDR_STATUS, v);
		chk("running", 16'h0001, v);
		k = n_rep;
		while (n_rep < k + 2) @(posedge mclk);
		@(posedge mclk);
		chk("gap", 16'd20, 16'(gap));
		chk("interval kind", 16'(KIND_INTERVAL), 16'(kind));
		chk("seconds", 16'h0004, 16'(sec));
		chk("minutes", 16'h0000, 16'(stamp_minutes));
		chk("hours", 16'h0000, 16'(stamp_hours));
		key(16'h0001);
		settle;
		chk("stopped", 16'h0000, 16'(interval_active));
		key(16'h0001);
		wr(ADDR_CONFIG, 16'h0002);
		settle;
		chk("halted", 16'h0000, 16'(interval_active));
		report_and_stop();
	end
endmodule : report_scheduler_tb
